//--- rtl/sudpm_params.svh
`ifndef SUDPM_PARAMS_SVH
`define SUDPM_PARAMS_SVH

// Register indices; byte address is four times the index
`define SUDPM_IDX_FWD_CTRL 8'h0e
`define SUDPM_IDX_MAC_HI 8'h10
`define SUDPM_IDX_MAC_MID 8'h12
`define SUDPM_IDX_MAC_LO 8'h14
`define SUDPM_IDX_DSCP 8'h16

// Avalon address and data widths
`define SUDPM_ADDR_W 10
`define SUDPM_DATA_W 32

// Forwarding control field layout
`define SUDPM_FWD_EN_BIT 7
`define SUDPM_FWD_MASK_MSB 2
`define SUDPM_FWD_RSVD_VAL 16'h0800

// Reset values
`define SUDPM_FWD_EN_RST 1'h0
`define SUDPM_FWD_MASK_RST 3'h7
`define SUDPM_MAC_LO_RST 16'hffff
`define SUDPM_DSCP_RST 16'h0000
`define SUDPM_RDATA_RST 32'h0000_0000

// Port set used when unknown-destination steering is off
`define SUDPM_ALL_PORTS 3'h7

// Classifier constants
`define SUDPM_DSCP_FIELDS 8
`define SUDPM_DSCP_TOP 6'h07

`endif

//--- rtl/sudpm_pkg.sv
package sudpm_pkg;

  // Register selected by a bus address
  typedef enum logic [2:0] {
    SUDPM_SEL_NONE,
    SUDPM_SEL_FWD,
    SUDPM_SEL_MAC_HI,
    SUDPM_SEL_MAC_MID,
    SUDPM_SEL_MAC_LO,
    SUDPM_SEL_DSCP
  } sudpm_sel_type;

  // Register bank state
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic fwd_en;
    logic [2:0] fwd_mask;
    logic [15:0] mac_hi;
    logic [15:0] mac_mid;
    logic [15:0] mac_lo;
    logic [15:0] dscp_map;
  } sudpm_regs_type;

  // Unknown-destination decision state
  typedef struct packed {
    logic valid;
    logic [2:0] ports;
  } sudpm_fwd_type;

  // DSCP lookup state
  typedef struct packed {
    logic valid;
    logic hit;
    logic [1:0] prio;
  } sudpm_dscp_type;

endpackage : sudpm_pkg

//--- rtl/sudpm_unknown_fwd.sv
`timescale 1ns/1ps
`include "sudpm_params.svh"

module sudpm_unknown_fwd
(
  input wire logic mclk_in, // Core clock
  input wire logic rst_b_in, // Synchronous reset, active low
  input wire logic fwd_en_in, // Unknown-destination steering enable
  input wire logic [2:0] fwd_mask_in, // Unknown-destination port mask
  input wire logic lookup_valid_in, // Lookup result strobe
  input wire logic lookup_miss_in, // Destination absent from table
  output logic fwd_valid_out, // Port set strobe for a miss
  output logic [2:0] fwd_ports_out // Ports to send the frame to
);

  sudpm_pkg::sudpm_fwd_type q;
  sudpm_pkg::sudpm_fwd_type d;

  // Pick the port set for a frame whose destination is unknown
  always_comb
  begin
    d = q;
    d.valid = lookup_valid_in & lookup_miss_in;
    if (lookup_valid_in && lookup_miss_in)
    begin
      if (fwd_en_in)
        d.ports = fwd_mask_in;
      else
        d.ports = `SUDPM_ALL_PORTS;
    end
  end

  // State register
  always_ff @(posedge mclk_in)
  begin
    if (!rst_b_in)
    begin
      q.valid <= 1'b0;
      q.ports <= 3'h0;
    end
    else
    begin
      q <= d;
    end
  end

  assign fwd_valid_out = q.valid;
  assign fwd_ports_out = q.ports;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_miss_en;
    lookup_valid_in && lookup_miss_in && fwd_en_in;
  endsequence

  a_miss_uses_mask: assert property (s_miss_en |=> fwd_valid_out && fwd_ports_out == $past(fwd_mask_in))
    else $error("Unknown destination not sent to masked ports");
  a_mask_ignored_off: assert property (lookup_valid_in && lookup_miss_in && !fwd_en_in |=> fwd_ports_out == 3'h7)
    else $error("Port mask applied while steering disabled");

endmodule : sudpm_unknown_fwd

//--- rtl/sudpm_dscp_map.sv
`timescale 1ns/1ps
`include "sudpm_params.svh"

module sudpm_dscp_map
(
  input wire logic mclk_in, // Core clock
  input wire logic rst_b_in, // Synchronous reset, active low
  input wire logic [15:0] map_in, // Priority fields for DSCP 0 to 7
  input wire logic cls_valid_in, // Classifier strobe
  input wire logic cls_is_ip_in, // Frame recognised as IPv4 or IPv6
  input wire logic [5:0] cls_dscp_in, // DSCP of the frame
  output logic prio_valid_out, // Lookup result strobe
  output logic prio_hit_out, // Priority came from this table
  output logic [1:0] prio_out // Mapped priority
);

  sudpm_pkg::sudpm_dscp_type q;
  sudpm_pkg::sudpm_dscp_type d;
  logic [1:0] field [`SUDPM_DSCP_FIELDS];

  // Split the map into one 2-bit field per DSCP value 0 to 7
  genvar gi;
  generate
    for (gi = 0; gi < `SUDPM_DSCP_FIELDS; gi++)
    begin : g_field
      assign field[gi] = map_in[2 * gi + 1 -: 2];
    end
  endgenerate

  // Look up IP frames whose DSCP falls in this table
  always_comb
  begin
    d = q;
    d.valid = cls_valid_in;
    d.hit = 1'b0;
    d.prio = 2'h0;
    if (cls_valid_in && cls_is_ip_in && cls_dscp_in <= `SUDPM_DSCP_TOP)
    begin
      d.hit = 1'b1;
      d.prio = field[cls_dscp_in[2:0]];
    end
  end

  // State register
  always_ff @(posedge mclk_in)
  begin
    if (!rst_b_in)
    begin
      q.valid <= 1'b0;
      q.hit <= 1'b0;
      q.prio <= 2'h0;
    end
    else
    begin
      q <= d;
    end
  end

  assign prio_valid_out = q.valid;
  assign prio_hit_out = q.hit;
  assign prio_out = q.prio;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);

  a_field_select: assert property (cls_valid_in && cls_is_ip_in && cls_dscp_in < 6'h08 |=>
      prio_hit_out && prio_out == $past(map_in[{cls_dscp_in[2:0], 1'b1} -: 2]))
    else $error("DSCP priority not taken from its field");
  a_non_ip_skip: assert property (cls_valid_in && !cls_is_ip_in |=> prio_valid_out && !prio_hit_out)
    else $error("Non-IP frame was mapped");
  a_upper_dscp_skip: assert property (cls_valid_in && cls_dscp_in > 6'h07 |=> !prio_hit_out)
    else $error("DSCP above 7 hit the first table");

endmodule : sudpm_dscp_map

//--- rtl/sudpm_regbank.sv
// Contract
// - With the unknown-destination enable set, frames missing from the lookup table go to the masked ports, else the mask is ignored.
// - A three-bit port mask (bit 2 host port 3, bit 1 port 2, bit 0 port 1) resets to all ones and acts only while enabled.
// - PAUSE frames carry the 48-bit source address built from three 16-bit registers, high bits at the lowest offset.
// - A 2-bit priority is kept for each of the 64 DSCP values of received IP frames; this bank keeps only the first map register, values 0 to 7.
// - DSCP values 0 to 7 take their priority from the first map register, value n from bits 2n+1:2n.
// - Every priority field of the first map register reads zero after reset.
`timescale 1ns/1ps
`include "sudpm_params.svh"

module sudpm_regbank
#(
  parameter logic [15:0] MAC_HI_RST = 16'h0200, // Arbitrary value
  parameter logic [15:0] MAC_MID_RST = 16'h0000 // Arbitrary value
)
(
  input wire logic mclk_in, // Core clock, 200 MHz
  input wire logic rst_b_in, // Synchronous reset, active low
  input wire logic [`SUDPM_ADDR_W-1:0] avs_address_in, // Avalon byte address
  input wire logic avs_read_in, // Avalon read
  input wire logic avs_write_in, // Avalon write
  input wire logic [`SUDPM_DATA_W-1:0] avs_writedata_in, // Avalon write data
  input wire logic [3:0] avs_byteenable_in, // Avalon byte enables
  output logic [`SUDPM_DATA_W-1:0] avs_readdata_out, // Avalon read data
  output logic avs_waitrequest_out, // Avalon wait request
  input wire logic lookup_valid_in, // Address lookup result strobe
  input wire logic lookup_miss_in, // Destination not in lookup table
  output logic unknown_fwd_valid_out, // Port set strobe for a miss
  output logic [2:0] unknown_fwd_ports_out, // Ports for the unknown frame
  input wire logic cls_valid_in, // Classifier strobe
  input wire logic cls_is_ip_in, // Frame is IPv4 or IPv6
  input wire logic [5:0] cls_dscp_in, // DSCP of the frame
  output logic cls_prio_valid_out, // Priority result strobe
  output logic cls_prio_hit_out, // Priority came from DSCP 0 to 7 table
  output logic [1:0] cls_prio_out, // Mapped priority
  output logic [47:0] pause_source_address_out // PAUSE frame source address
);

  sudpm_pkg::sudpm_regs_type q;
  sudpm_pkg::sudpm_regs_type d;
  sudpm_pkg::sudpm_sel_type sel;
  logic req;
  logic [15:0] rd_word;

  // Map a register index to the register it selects
  function automatic sudpm_pkg::sudpm_sel_type decode_idx(input logic [7:0] idx);
    sudpm_pkg::sudpm_sel_type s;
    s = sudpm_pkg::SUDPM_SEL_NONE;
    unique case (idx)
      `SUDPM_IDX_FWD_CTRL: s = sudpm_pkg::SUDPM_SEL_FWD;
      `SUDPM_IDX_MAC_HI: s = sudpm_pkg::SUDPM_SEL_MAC_HI;
      `SUDPM_IDX_MAC_MID: s = sudpm_pkg::SUDPM_SEL_MAC_MID;
      `SUDPM_IDX_MAC_LO: s = sudpm_pkg::SUDPM_SEL_MAC_LO;
      `SUDPM_IDX_DSCP: s = sudpm_pkg::SUDPM_SEL_DSCP;
      default: s = sudpm_pkg::SUDPM_SEL_NONE;
    endcase
    return s;
  endfunction : decode_idx

  // Merge a write into a 16-bit register under the two low byte lanes
  function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [15:0] new_v,
                                           input logic [1:0] be);
    logic [15:0] r;
    r = old_v;
    if (be[0])
      r[7:0] = new_v[7:0];
    if (be[1])
      r[15:8] = new_v[15:8];
    return merge16_done(r);
  endfunction : merge16

  // Identity helper that keeps the merge result width explicit
  function automatic logic [15:0] merge16_done(input logic [15:0] v);
    return v;
  endfunction : merge16_done

  // Bus request and register select
  assign req = avs_read_in | avs_write_in;
  assign sel = decode_idx(avs_address_in[`SUDPM_ADDR_W-1:2]);

  // Read view of the selected register; unmapped places read zero, reserved control bits read as 16'h0800
  always_comb
  begin
    rd_word = 16'h0000;
    unique case (sel)
      sudpm_pkg::SUDPM_SEL_FWD:
      begin
        rd_word = `SUDPM_FWD_RSVD_VAL;
        rd_word[`SUDPM_FWD_EN_BIT] = q.fwd_en;
        rd_word[`SUDPM_FWD_MASK_MSB:0] = q.fwd_mask;
      end
      sudpm_pkg::SUDPM_SEL_MAC_HI: rd_word = q.mac_hi;
      sudpm_pkg::SUDPM_SEL_MAC_MID: rd_word = q.mac_mid;
      sudpm_pkg::SUDPM_SEL_MAC_LO: rd_word = q.mac_lo;
      sudpm_pkg::SUDPM_SEL_DSCP: rd_word = q.dscp_map;
      sudpm_pkg::SUDPM_SEL_NONE: rd_word = 16'h0000;
    endcase
  end

  // One wait state: read data is loaded in the first cycle, writes land on the release edge
  always_comb
  begin
    d = q;
    d.ack = req & ~q.ack;
    if (req && !q.ack)
      d.rdata = {16'h0000, rd_word};
    if (avs_write_in && q.ack)
    begin
      unique case (sel)
        sudpm_pkg::SUDPM_SEL_FWD:
        begin
          if (avs_byteenable_in[0])
          begin
            d.fwd_en = avs_writedata_in[`SUDPM_FWD_EN_BIT];
            d.fwd_mask = avs_writedata_in[`SUDPM_FWD_MASK_MSB:0];
          end
        end
        sudpm_pkg::SUDPM_SEL_MAC_HI:
          d.mac_hi = merge16(q.mac_hi, avs_writedata_in[15:0], avs_byteenable_in[1:0]);
        sudpm_pkg::SUDPM_SEL_MAC_MID:
          d.mac_mid = merge16(q.mac_mid, avs_writedata_in[15:0], avs_byteenable_in[1:0]);
        sudpm_pkg::SUDPM_SEL_MAC_LO:
          d.mac_lo = merge16(q.mac_lo, avs_writedata_in[15:0], avs_byteenable_in[1:0]);
        sudpm_pkg::SUDPM_SEL_DSCP:
          d.dscp_map = merge16(q.dscp_map, avs_writedata_in[15:0], avs_byteenable_in[1:0]);
        sudpm_pkg::SUDPM_SEL_NONE:
          d.ack = 1'b0;
      endcase
    end
  end

  // State register with documented reset values
  always_ff @(posedge mclk_in)
  begin
    if (!rst_b_in)
    begin
      q.ack <= 1'b0;
      q.rdata <= `SUDPM_RDATA_RST;
      q.fwd_en <= `SUDPM_FWD_EN_RST;
      q.fwd_mask <= `SUDPM_FWD_MASK_RST;
      q.mac_hi <= MAC_HI_RST;
      q.mac_mid <= MAC_MID_RST;
      q.mac_lo <= `SUDPM_MAC_LO_RST;
      q.dscp_map <= `SUDPM_DSCP_RST;
    end
    else
    begin
      q <= d;
    end
  end

  // Bus answers
  assign avs_waitrequest_out = req & ~q.ack;
  assign avs_readdata_out = q.rdata;

  // PAUSE source address, high word at the lowest offset
  assign pause_source_address_out = {q.mac_hi, q.mac_mid, q.mac_lo};

  // Unknown-destination port selection
  sudpm_unknown_fwd u_unknown_fwd
  (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .fwd_en_in(q.fwd_en),
    .fwd_mask_in(q.fwd_mask),
    .lookup_valid_in(lookup_valid_in),
    .lookup_miss_in(lookup_miss_in),
    .fwd_valid_out(unknown_fwd_valid_out),
    .fwd_ports_out(unknown_fwd_ports_out)
  );

  // DSCP to priority lookup for values 0 to 7
  sudpm_dscp_map u_dscp_map
  (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .map_in(q.dscp_map),
    .cls_valid_in(cls_valid_in),
    .cls_is_ip_in(cls_is_ip_in),
    .cls_dscp_in(cls_dscp_in),
    .prio_valid_out(cls_prio_valid_out),
    .prio_hit_out(cls_prio_hit_out),
    .prio_out(cls_prio_out)
  );

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);

  // Write accepted on the release edge
  sequence s_write_done(logic [7:0] idx);
    avs_write_in && !avs_waitrequest_out && avs_byteenable_in[1:0] == 2'b11
      && avs_address_in[`SUDPM_ADDR_W-1:2] == idx;
  endsequence

  // Access held over its wait state
  sequence s_held_access;
    req && avs_waitrequest_out ##1 req;
  endsequence

  a_one_wait_state: assert property (s_held_access |-> !avs_waitrequest_out)
    else $error("Access not released after one wait state");
  a_mac_lo_write: assert property (s_write_done(`SUDPM_IDX_MAC_LO) |=>
      pause_source_address_out[15:0] == $past(avs_writedata_in[15:0]))
    else $error("Low PAUSE address word not updated");
  a_mac_hi_write: assert property (s_write_done(`SUDPM_IDX_MAC_HI) |=>
      pause_source_address_out[47:32] == $past(avs_writedata_in[15:0]))
    else $error("High PAUSE address word not updated");
  a_mask_reset: assert property ($rose(rst_b_in) |-> q.fwd_mask == 3'h7 && !q.fwd_en)
    else $error("Port mask not all ones after reset");
  a_dscp_reset: assert property ($rose(rst_b_in) |-> q.dscp_map == 16'h0000)
    else $error("DSCP map not zero after reset");
  a_fwd_readback: assert property (avs_read_in && avs_waitrequest_out
      && avs_address_in[`SUDPM_ADDR_W-1:2] == 8'h0e ##1 avs_read_in |->
      avs_readdata_out[7] == q.fwd_en && avs_readdata_out[2:0] == q.fwd_mask)
    else $error("Forwarding control reads back wrong");
  a_dscp_next_frame: assert property (s_write_done(`SUDPM_IDX_DSCP) ##2
      (cls_valid_in && cls_is_ip_in && cls_dscp_in == 6'h00) |=> cls_prio_out == $past(q.dscp_map[1:0], 1))
    else $error("DSCP write not applied to next frame");
  a_mask_to_fwd: assert property (s_write_done(`SUDPM_IDX_FWD_CTRL) && avs_writedata_in[7] ##2
      (lookup_valid_in && lookup_miss_in) |=> unknown_fwd_ports_out == $past(avs_writedata_in[2:0], 3))
    else $error("Written mask not used for unknown frames");

endmodule : sudpm_regbank

//--- bench/sudpm_tb.sv
`timescale 1ns/1ps
`include "sudpm_params.svh"

module tb;
  logic mclk_in;
  logic rst_b_in;
  logic [9:0] avs_address_in;
  logic avs_read_in;
  logic avs_write_in;
  logic [31:0] avs_writedata_in;
  logic [3:0] avs_byteenable_in;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic lookup_valid_in;
  logic lookup_miss_in;
  logic unknown_fwd_valid_out;
  logic [2:0] unknown_fwd_ports_out;
  logic cls_valid_in;
  logic cls_is_ip_in;
  logic [5:0] cls_dscp_in;
  logic cls_prio_valid_out;
  logic cls_prio_hit_out;
  logic [1:0] cls_prio_out;
  logic [47:0] pause_source_address_out;
  int n_errors;
  int samples_checked;
  int cycles;
  logic [31:0] rd;
  logic [15:0] map;

  localparam logic [9:0] A_CTRL = {`SUDPM_IDX_FWD_CTRL, 2'b00};
  localparam logic [9:0] A_HI = {`SUDPM_IDX_MAC_HI, 2'b00};
  localparam logic [9:0] A_MID = {`SUDPM_IDX_MAC_MID, 2'b00};
  localparam logic [9:0] A_LO = {`SUDPM_IDX_MAC_LO, 2'b00};
  localparam logic [9:0] A_DSCP = {`SUDPM_IDX_DSCP, 2'b00};

  sudpm_regbank dut
  (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .lookup_valid_in(lookup_valid_in),
    .lookup_miss_in(lookup_miss_in),
    .unknown_fwd_valid_out(unknown_fwd_valid_out),
    .unknown_fwd_ports_out(unknown_fwd_ports_out),
    .cls_valid_in(cls_valid_in),
    .cls_is_ip_in(cls_is_ip_in),
    .cls_dscp_in(cls_dscp_in),
    .cls_prio_valid_out(cls_prio_valid_out),
    .cls_prio_hit_out(cls_prio_hit_out),
    .cls_prio_out(cls_prio_out),
    .pause_source_address_out(pause_source_address_out)
  );

  // Clock at 200 MHz
  always #2.5 mclk_in = ~mclk_in;

  // Verdict and end of run
  task stop_test;
    if (n_errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test

  // Watchdog against a hung bus or stuck handshake
  always @(posedge mclk_in)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      n_errors++;
      stop_test();
    end
  end

  // Case-equal compare with a report on mismatch
  task chk(input logic [47:0] got, input logic [47:0] exp, input string msg);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  // Hold reset low for six cycles, then release
  task reset_dut;
    rst_b_in <= 1'b0;
    repeat (6) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    @(posedge mclk_in);
  endtask : reset_dut

  // One Avalon access; request held until waitrequest is seen low at an edge
  task bus(input logic wr, input logic [9:0] a, input logic [15:0] d, input logic [3:0] be);
    int n;
    n = 0;
    avs_address_in <= a;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    avs_writedata_in <= {16'h0000, d};
    avs_byteenable_in <= be;
    do
    begin
      @(posedge mclk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 50);
    if (n >= 50)
      chk(48'h0000_0000_0001, 48'h0000_0000_0000, "bus access never answered");
    rd = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    // Idle edge so the next request never reassigns a strobe in this time step
    @(posedge mclk_in);
  endtask : bus

  // Read a register and compare its 16-bit value
  task rd_chk(input logic [9:0] a, input logic [15:0] exp, input string msg);
    bus(1'b0, a, 16'h0000, 4'h0);
    chk({16'h0000, rd}, {32'h0000_0000, exp}, msg);
  endtask : rd_chk

  // Present one lookup result and check the unknown-destination answer
  task lookup(input logic miss, input logic vexp, input logic [2:0] pexp);
    lookup_valid_in <= 1'b1;
    lookup_miss_in <= miss;
    @(posedge mclk_in);
    lookup_valid_in <= 1'b0;
    lookup_miss_in <= 1'b0;
    @(posedge mclk_in);
    chk({47'h0, unknown_fwd_valid_out}, {47'h0, vexp}, "unknown fwd strobe");
    if (vexp)
      chk({45'h0, unknown_fwd_ports_out}, {45'h0, pexp}, "unknown fwd ports");
  endtask : lookup

  // Classify one frame and check the priority answer
  task classify(input logic ip, input logic [5:0] dscp, input logic hexp, input logic [1:0] pexp);
    cls_valid_in <= 1'b1;
    cls_is_ip_in <= ip;
    cls_dscp_in <= dscp;
    @(posedge mclk_in);
    cls_valid_in <= 1'b0;
    @(posedge mclk_in);
    chk({47'h0, cls_prio_valid_out}, 48'h0000_0000_0001, "prio strobe");
    chk({45'h0, cls_prio_hit_out, cls_prio_out}, {45'h0, hexp, pexp}, "prio hit and value");
  endtask : classify

  // Main sequence
  initial
  begin
    mclk_in = 1'b0;
    rst_b_in = 1'b0;
    avs_address_in = 10'h000;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_writedata_in = 32'h0000_0000;
    avs_byteenable_in = 4'h0;
    lookup_valid_in = 1'b0;
    lookup_miss_in = 1'b0;
    cls_valid_in = 1'b0;
    cls_is_ip_in = 1'b0;
    cls_dscp_in = 6'h00;
    n_errors = 0;
    samples_checked = 0;
    cycles = 0;
    reset_dut();
    // Reset values of every register and of the pause address
    rd_chk(A_CTRL, 16'h0807, "control reset");
    rd_chk(A_HI, 16'h0200, "high reset");
    rd_chk(A_MID, 16'h0000, "middle reset");
    rd_chk(A_LO, 16'hffff, "low reset");
    rd_chk(A_DSCP, 16'h0000, "map reset");
    chk(pause_source_address_out, 48'h0200_0000_ffff, "pause addr reset");
    // Steering off: a miss goes everywhere, a hit gives nothing
    lookup(1'b1, 1'b1, 3'h7);
    lookup(1'b0, 1'b0, 3'h0);
    // Mask with steering off has no effect
    bus(1'b1, A_CTRL, 16'h0002, 4'h1);
    lookup(1'b1, 1'b1, 3'h7);
    // Every mask value with steering on, read-only upper byte untouched
    for (int m = 0; m < 8; m++)
    begin
      bus(1'b1, A_CTRL, 16'hff80 | 16'(m), 4'h3);
      lookup(1'b1, 1'b1, 3'(m));
      rd_chk(A_CTRL, 16'h0880 | 16'(m), "control readback");
    end
    // Write without lane 0 leaves control alone
    bus(1'b1, A_CTRL, 16'h0003, 4'h2);
    rd_chk(A_CTRL, 16'h0887, "control lane 1 only");
    // Pause source address built from three registers
    bus(1'b1, A_HI, 16'h1a2b, 4'h3);
    bus(1'b1, A_MID, 16'h3c4d, 4'h3);
    bus(1'b1, A_LO, 16'h5e6f, 4'h3);
    chk(pause_source_address_out, 48'h1a2b_3c4d_5e6f, "pause addr");
    bus(1'b1, A_LO, 16'h1234, 4'h1);
    rd_chk(A_LO, 16'h5e34, "low lane 0 only");
    chk(pause_source_address_out, 48'h1a2b_3c4d_5e34, "pause addr lane 0");
    // Unmapped places read zero and ignore writes
    bus(1'b1, 10'h03c, 16'habcd, 4'h3);
    rd_chk(10'h03c, 16'h0000, "unmapped low");
    bus(1'b1, 10'h3fc, 16'habcd, 4'h3);
    rd_chk(10'h3fc, 16'h0000, "unmapped high");
    // Map after reset gives lowest priority
    classify(1'b1, 6'h05, 1'b1, 2'h0);
    // New map used by a frame classified right after the write
    map = 16'h1be4;
    bus(1'b1, A_DSCP, map, 4'h3);
    classify(1'b1, 6'h00, 1'b1, map[1:0]);
    for (int n = 0; n < 8; n++)
      classify(1'b1, 6'(n), 1'b1, map[2 * n +: 2]);
    rd_chk(A_DSCP, map, "map readback");
    // Non-IP frames and values outside this table
    classify(1'b0, 6'h03, 1'b0, 2'h0);
    classify(1'b1, 6'h08, 1'b0, 2'h0);
    classify(1'b1, 6'h3f, 1'b0, 2'h0);
    // Second reset in mid-run restores defaults
    reset_dut();
    rd_chk(A_CTRL, 16'h0807, "control after reset");
    rd_chk(A_DSCP, 16'h0000, "map after reset");
    chk(pause_source_address_out, 48'h0200_0000_ffff, "pause addr after reset");
    lookup(1'b1, 1'b1, 3'h7);
    stop_test();
  end
endmodule : tb
